//--- logic/wpc_target.sv
// target end: receives address, command and data, holds live and stored wiper
// assumes the controller makes scl; a pin clock is sampled by hclk
module wpc_target #(
    parameter bit THREE_TERMINAL = 1'b1,
    parameter bit FACTORY_ADDR_BIT_TWO = 1'b0,
    parameter bit FACTORY_ADDR_BIT_ONE = 1'b0,
    parameter bit FACTORY_ADDR_BIT_ZERO = 1'b0,
    parameter int NV_STORE_CYC = wpc_pkg::NV_STORE_CYC
) (
    // clock and resets
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic factory_clear_n,
    // address select pin
    input wire logic pin_selected_addr_bit,
    // link
    wpc_link_if.device link,
    // wiper state
    output logic [4:0] wiper_position,
    output logic store_busy
);
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sel_meta_q;
    logic sel_q;
    wpc_pkg::wpc_tstate_t state_q;
    wpc_pkg::wpc_tstate_t state_d;
    logic [3:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] cmd_q;
    logic ack_q;
    logic ack_d;
    logic sda_oe_q;
    logic [4:0] live_q;
    logic [4:0] store_q;
    logic boot_q;
    logic nv_pend_q;
    logic busy_q;
    logic [wpc_pkg::NV_CNT_W-1:0] nv_cnt_q;
    logic [6:0] own_addr;
    logic [7:0] byte_val;
    logic byte_done;
    logic exec;

    wpc_line_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .scl_in(link.scl),
        .sda_in(link.sda),
        .scl(scl_s),
        .sda(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen)
    );

    // select pin sampled through two flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_meta_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            sel_meta_q <= pin_selected_addr_bit;
            sel_q <= sel_meta_q;
        end
    end

    assign own_addr = {wpc_pkg::ADDR_FIXED, FACTORY_ADDR_BIT_TWO, FACTORY_ADDR_BIT_ONE,
        THREE_TERMINAL ? sel_q : FACTORY_ADDR_BIT_ZERO};
    assign byte_val = {shift_q, sda_s};
    assign byte_done = scl_rise && (bit_cnt_q == wpc_pkg::LAST_DATA_BIT)
        && (state_q != wpc_pkg::T_IDLE);
    assign exec = byte_done && (state_q == wpc_pkg::T_DATA);

    // next state and acknowledge decision per received byte
    always_comb begin
        state_d = state_q;
        ack_d = 1'b0;
        case (state_q)
            wpc_pkg::T_ADDR: begin
                if (byte_val[7:1] == own_addr && !busy_q && !boot_q) begin
                    ack_d = 1'b1;
                    state_d = byte_val[0] ? wpc_pkg::T_DONE : wpc_pkg::T_CMD;
                end else begin
                    state_d = wpc_pkg::T_SKIP;
                end
            end
            wpc_pkg::T_CMD: begin
                ack_d = 1'b1;
                state_d = wpc_pkg::T_DATA;
            end
            wpc_pkg::T_DATA, wpc_pkg::T_DONE: begin
                ack_d = 1'b1;
                state_d = wpc_pkg::T_DONE;
            end
            wpc_pkg::T_SKIP: begin
                state_d = wpc_pkg::T_SKIP;
            end
            default: begin
                state_d = wpc_pkg::T_IDLE;
            end
        endcase
    end

    // frame sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= wpc_pkg::T_IDLE;
            ack_q <= 1'b0;
        end else if (stop_seen) begin
            state_q <= wpc_pkg::T_IDLE;
            ack_q <= 1'b0;
        end else if (start_seen) begin
            state_q <= wpc_pkg::T_ADDR;
            ack_q <= 1'b0;
        end else if (byte_done) begin
            state_q <= state_d;
            ack_q <= ack_d;
        end
    end

    // bit counter and shift register, sampled on scl rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 7'h00;
        end else if (start_seen) begin
            bit_cnt_q <= 4'h0;
        end else if (scl_rise) begin
            if (bit_cnt_q == wpc_pkg::ACK_BIT) begin
                bit_cnt_q <= 4'h0;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                shift_q <= {shift_q[5:0], sda_s};
            end
        end
    end

    // command capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_q <= 8'h00;
        end else if (byte_done && state_q == wpc_pkg::T_CMD) begin
            cmd_q <= byte_val;
        end
    end

    // acknowledge drive: set after eighth fall, released after ninth
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sda_oe_q <= 1'b0;
        end else if (start_seen || stop_seen) begin
            sda_oe_q <= 1'b0;
        end else if (scl_fall) begin
            sda_oe_q <= (bit_cnt_q == wpc_pkg::ACK_BIT) && ack_q;
        end
    end

    assign link.sda_d_oe = sda_oe_q;
    assign link.sda_d_out = 1'b0;

    // power-up recall flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    // live wiper register, cleared by hresetn then loaded from the store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            live_q <= wpc_pkg::LIVE_RESET;
        end else if (boot_q) begin
            live_q <= store_q;
        end else if (exec) begin
            case (cmd_q)
                wpc_pkg::CMD_LOAD_LIVE: live_q <= byte_val[7:3];
                wpc_pkg::CMD_RECALL: live_q <= store_q;
                default: live_q <= live_q;
            endcase
        end
    end

    // nonvolatile store, kept across hresetn
    always_ff @(posedge hclk or negedge factory_clear_n) begin
        if (!factory_clear_n) begin
            store_q <= wpc_pkg::STORE_FACTORY;
        end else if (exec) begin
            case (cmd_q)
                wpc_pkg::CMD_LOAD_STORED: store_q <= byte_val[7:3];
                wpc_pkg::CMD_SAVE: store_q <= live_q;
                default: store_q <= store_q;
            endcase
        end
    end

    // programming time, started by the stop that ends a store write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nv_pend_q <= 1'b0;
            busy_q <= 1'b0;
            nv_cnt_q <= '0;
        end else begin
            if (exec && wpc_pkg::nv_write(cmd_q)) begin
                nv_pend_q <= 1'b1;
            end else if (stop_seen) begin
                nv_pend_q <= 1'b0;
            end
            if (stop_seen && nv_pend_q) begin
                busy_q <= 1'b1;
                nv_cnt_q <= wpc_pkg::NV_CNT_W'(NV_STORE_CYC - 1);
            end else if (busy_q) begin
                if (nv_cnt_q == '0) begin
                    busy_q <= 1'b0;
                end else begin
                    nv_cnt_q <= nv_cnt_q - wpc_pkg::NV_CNT_W'(1);
                end
            end
        end
    end

    assign wiper_position = live_q;
    assign store_busy = busy_q;
endmodule : wpc_target

//--- logic/wpc_pkg.sv
// shared constants, command codes and state types for the wiper control link
// assumes one 25 MHz system clock on both ends
package wpc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam int QTR_CYC = LINK_PERIOD_NS / 4 / CLK_PERIOD_NS;
    localparam int NV_STORE_MS = 12;
    localparam int NV_STORE_CYC = NV_STORE_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int NV_CNT_W = 19;
    localparam int FRAME_BITS = 27;
    localparam logic [3:0] ADDR_FIXED = 4'h5;
    localparam logic [7:0] CMD_LOAD_LIVE = 8'h11;
    localparam logic [7:0] CMD_LOAD_STORED = 8'h21;
    localparam logic [7:0] CMD_RECALL = 8'h61;
    localparam logic [7:0] CMD_SAVE = 8'h51;
    localparam logic [4:0] STORE_FACTORY = 5'h00;
    localparam logic [4:0] LIVE_RESET = 5'h00;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    // controller registers
    localparam logic [7:0] FRAME_OFS = 8'h00;
    localparam logic [7:0] GO_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam int FR_ADDR_LSB = 0;
    localparam int FR_OP_BIT = 7;
    localparam int FR_CMD_LSB = 8;
    localparam int FR_DATA_LSB = 16;
    localparam int ST_BUSY = 0;
    localparam int ST_NACK = 1;
    localparam int ST_WAIT = 2;

    typedef enum logic [2:0] {
        T_IDLE = 3'b000,
        T_ADDR = 3'b001,
        T_CMD = 3'b010,
        T_DATA = 3'b011,
        T_DONE = 3'b100,
        T_SKIP = 3'b101
    } wpc_tstate_t;

    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_START = 3'b001,
        C_BIT = 3'b010,
        C_STOP = 3'b011,
        C_WAIT = 3'b100
    } wpc_cstate_t;

    // commands that program the nonvolatile store
    function automatic logic nv_write(input logic [7:0] cmd);
        return (cmd == CMD_LOAD_STORED) || (cmd == CMD_SAVE);
    endfunction : nv_write
endpackage : wpc_pkg

//--- logic/wpc_link_if.sv
// two-wire link between controller and target, open-drain lines resolved here
// assumes pullups: a line is high unless some end enables a low drive
interface wpc_link_if;
    logic scl_c_out;
    logic scl_c_oe;
    logic sda_c_out;
    logic sda_c_oe;
    logic sda_d_out;
    logic sda_d_oe;
    logic scl;
    logic sda;

    assign scl = scl_c_oe ? scl_c_out : 1'b1;
    assign sda = (sda_c_oe ? sda_c_out : 1'b1) & (sda_d_oe ? sda_d_out : 1'b1);

    modport device (input scl, input sda, output sda_d_out, output sda_d_oe);
    modport ctrl (input scl, input sda, output scl_c_out, output scl_c_oe,
        output sda_c_out, output sda_c_oe);
endinterface : wpc_link_if

//--- logic/wpc_line_sync.sv
// two-flop synchroniser for scl and sda with edge and start/stop detection
// assumes the raw lines are asynchronous to hclk
module wpc_line_sync (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // raw lines
    input wire logic scl_in,
    input wire logic sda_in,
    // conditioned levels and one-cycle events
    output logic scl,
    output logic sda,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
            prev_q <= 2'h3;
        end else begin
            meta_q <= {scl_in, sda_in};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign scl = sync_q[1];
    assign sda = sync_q[0];
    assign scl_rise = sync_q[1] & ~prev_q[1];
    assign scl_fall = ~sync_q[1] & prev_q[1];
    assign start_seen = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
    assign stop_seen = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];
endmodule : wpc_line_sync

//--- logic/wpc_controller.sv
// controller end: AHB-Lite registers start one frame on the two-wire link
// assumes a single AHB-Lite master; scl is made here by a divider
module wpc_controller #(
    parameter int NV_STORE_CYC = wpc_pkg::NV_STORE_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // link
    wpc_link_if.ctrl link
);
    logic sda_s;
    wpc_pkg::wpc_cstate_t state_q;
    logic [23:0] frame_q;
    logic [26:0] shift_q;
    logic [4:0] bit_idx_q;
    logic [1:0] qtr_q;
    logic [1:0] div_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic nack_q;
    logic nv_req_q;
    logic [wpc_pkg::NV_CNT_W-1:0] wait_cnt_q;
    logic wr_q;
    logic [7:0] ap_addr_q;
    logic [31:0] rdata_q;
    logic go;
    logic tick;
    logic ack_pos;
    logic nack_now;
    logic enter_stop;

    wpc_line_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .scl_in(link.scl),
        .sda_in(link.sda),
        .scl(),
        .sda(sda_s),
        .scl_rise(),
        .scl_fall(),
        .start_seen(),
        .stop_seen()
    );

    // bus address phase and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                ap_addr_q <= haddr[7:0];
                case (haddr[7:0])
                    wpc_pkg::FRAME_OFS: rdata_q <= {8'h00, frame_q};
                    wpc_pkg::STATUS_OFS: rdata_q <= {29'h0000_0000,
                        state_q == wpc_pkg::C_WAIT, nack_q, state_q != wpc_pkg::C_IDLE};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // frame register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_q <= 24'h00_0000;
        end else if (wr_q && ap_addr_q == wpc_pkg::FRAME_OFS) begin
            frame_q <= hwdata[23:0];
        end
    end

    assign go = wr_q && (ap_addr_q == wpc_pkg::GO_OFS) && hwdata[0]
        && (state_q == wpc_pkg::C_IDLE);
    assign tick = (div_q == 2'h0) && (state_q != wpc_pkg::C_IDLE);
    assign ack_pos = (bit_idx_q == 5'h08) || (bit_idx_q == 5'h11) || (bit_idx_q == 5'h1a);
    assign nack_now = ack_pos && sda_s;
    assign enter_stop = tick && (state_q == wpc_pkg::C_BIT) && (qtr_q == 2'h3)
        && (nack_now || bit_idx_q == 5'(wpc_pkg::FRAME_BITS - 1));

    // quarter-bit enable divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 2'h0;
        end else if (state_q == wpc_pkg::C_IDLE || div_q == 2'h0) begin
            div_q <= 2'(wpc_pkg::QTR_CYC - 1);
        end else begin
            div_q <= div_q - 2'h1;
        end
    end

    // frame sequencer: start, 27 bits or fewer after a nack, stop, store wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= wpc_pkg::C_IDLE;
            qtr_q <= 2'h0;
            bit_idx_q <= 5'h00;
            shift_q <= 27'h000_0000;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            nack_q <= 1'b0;
            nv_req_q <= 1'b0;
        end else if (go) begin
            state_q <= wpc_pkg::C_START;
            qtr_q <= 2'h0;
            nack_q <= 1'b0;
            shift_q <= {frame_q[wpc_pkg::FR_ADDR_LSB +: 7], frame_q[wpc_pkg::FR_OP_BIT], 1'b1,
                frame_q[wpc_pkg::FR_CMD_LSB +: 8], 1'b1, frame_q[wpc_pkg::FR_DATA_LSB +: 8],
                1'b1};
            nv_req_q <= !frame_q[wpc_pkg::FR_OP_BIT]
                && wpc_pkg::nv_write(frame_q[wpc_pkg::FR_CMD_LSB +: 8]);
        end else if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            case (state_q)
                wpc_pkg::C_START: begin
                    if (qtr_q == 2'h1) sda_oe_q <= 1'b1;
                    if (qtr_q == 2'h3) begin
                        scl_oe_q <= 1'b1;
                        state_q <= wpc_pkg::C_BIT;
                        bit_idx_q <= 5'h00;
                    end
                end
                wpc_pkg::C_BIT: begin
                    if (qtr_q == 2'h0) sda_oe_q <= ~shift_q[26];
                    if (qtr_q == 2'h1) scl_oe_q <= 1'b0;
                    if (qtr_q == 2'h3) begin
                        scl_oe_q <= 1'b1;
                        shift_q <= {shift_q[25:0], 1'b1};
                        bit_idx_q <= bit_idx_q + 5'h01;
                        if (nack_now) nack_q <= 1'b1;
                        if (enter_stop) state_q <= wpc_pkg::C_STOP;
                    end
                end
                wpc_pkg::C_STOP: begin
                    if (qtr_q == 2'h0) sda_oe_q <= 1'b1;
                    if (qtr_q == 2'h1) scl_oe_q <= 1'b0;
                    if (qtr_q == 2'h2) sda_oe_q <= 1'b0;
                    if (qtr_q == 2'h3) begin
                        state_q <= (wait_cnt_q != '0) ? wpc_pkg::C_WAIT : wpc_pkg::C_IDLE;
                    end
                end
                wpc_pkg::C_WAIT: begin
                    if (wait_cnt_q == '0) state_q <= wpc_pkg::C_IDLE;
                end
                default: state_q <= wpc_pkg::C_IDLE;
            endcase
        end
    end

    // store idle time, counted from the start of the stop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt_q <= '0;
        end else if (enter_stop) begin
            wait_cnt_q <= (nv_req_q && !nack_now) ?
                wpc_pkg::NV_CNT_W'(NV_STORE_CYC - 1) : '0;
        end else if (wait_cnt_q != '0) begin
            wait_cnt_q <= wait_cnt_q - wpc_pkg::NV_CNT_W'(1);
        end
    end

    assign link.scl_c_oe = scl_oe_q;
    assign link.scl_c_out = 1'b0;
    assign link.sda_c_oe = sda_oe_q;
    assign link.sda_c_out = 1'b0;
endmodule : wpc_controller

//--- testbench/wpc_link_monitor.sv
// wire checks on the link: drives, ack timing, address, frame spacing
// assumes the interface signals of one link, all in the hclk domain
module wpc_link_monitor #(
    parameter int NV_STORE_CYC = 200
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // line drives
    input wire logic scl_c_out,
    input wire logic scl_c_oe,
    input wire logic sda_c_out,
    input wire logic sda_c_oe,
    input wire logic sda_d_out,
    input wire logic sda_d_oe,
    // resolved lines
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_q;
    logic sda_q;
    logic rise;
    logic start_ev;
    logic stop_ev;
    logic [4:0] cnt_q;
    logic [7:0] sh_q;
    logic op_q;
    logic nvw_q;
    logic [19:0] gap_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    assign rise = scl && !scl_q;
    assign start_ev = scl && scl_q && sda_q && !sda;
    assign stop_ev = scl && scl_q && !sda_q && sda;

    // previous line levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // clock pulses since start and the bits they carried
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 5'h00;
            sh_q <= 8'h00;
        end else if (start_ev) begin
            cnt_q <= 5'h00;
        end else if (rise) begin
            cnt_q <= (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
            sh_q <= {sh_q[6:0], sda};
        end
    end

    // op bit and whether the frame programs the store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_q <= 1'b0;
            nvw_q <= 1'b0;
        end else if (start_ev) begin
            nvw_q <= 1'b0;
        end else if (rise && cnt_q == 5'h07) begin
            op_q <= sda;
        end else if (rise && cnt_q == 5'h10) begin
            nvw_q <= !op_q && ({sh_q[6:0], sda} == wpc_pkg::CMD_LOAD_STORED
                || {sh_q[6:0], sda} == wpc_pkg::CMD_SAVE);
        end
    end

    // cycles since the last stop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_q <= 20'hf_ffff;
        end else if (stop_ev) begin
            gap_q <= 20'h0_0000;
        end else if (gap_q != 20'hf_ffff) begin
            gap_q <= gap_q + 20'h0_0001;
        end
    end

    property p_open_drain;
        !(scl_c_oe && scl_c_out) && !(sda_c_oe && sda_c_out) && !(sda_d_oe && sda_d_out);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");

    property p_ack_edge;
        $changed(sda_d_oe) |-> !scl;
    endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("ack moved, scl high");

    property p_bit_hold;
        scl && scl_q && cnt_q inside {[5'h01:5'h09]} |-> $stable(sda_c_oe);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("data moved, scl high");

    property p_ack_hold;
        $rose(sda_d_oe) |-> ##[1:6] (scl && sda_d_oe);
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack not held");

    property p_ack_count;
        $rose(sda_d_oe) |-> cnt_q inside {5'h08, 5'h11, 5'h1a};
    endproperty
    a_ack_count: assert property (p_ack_count) else $error("ack off ninth");

    property p_addr_match;
        $rose(sda_d_oe) && cnt_q == 5'h08 |-> sh_q[7:2] == 6'h14;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("bad addr acked");

    property p_stop_idle;
        stop_ev |-> (!scl_c_oe && !sda_c_oe)[*3];
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("bus not idle");

    property p_store_gap;
        start_ev && nvw_q |-> gap_q >= NV_STORE_CYC - 8;
    endproperty
    a_store_gap: assert property (p_store_gap) else $error("store wait short");
endmodule : wpc_link_monitor

//--- testbench/tb.sv
// self-checking bench: controller and target joined by the link interface
// assumes package, interface and both ends are compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NV = 200;
    logic hclk;
    logic hresetn;
    logic factory_clear_n;
    logic pin;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [4:0] wiper;
    logic store_busy;
    logic [9:0] exp_s;
    logic [31:0] rd;
    logic [7:0] cmds [6];
    int err_total;
    int check_count;

    wpc_link_if link ();
    wpc_target #(.NV_STORE_CYC(NV)) i_wpc_target (.hclk(hclk), .hresetn(hresetn),
        .factory_clear_n(factory_clear_n), .pin_selected_addr_bit(pin), .link(link),
        .wiper_position(wiper), .store_busy(store_busy));
    wpc_controller #(.NV_STORE_CYC(NV)) i_wpc_controller (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .link(link));
    wpc_link_monitor #(.NV_STORE_CYC(NV)) i_wpc_link_monitor (.hclk(hclk),
        .hresetn(hresetn), .scl_c_out(link.scl_c_out), .scl_c_oe(link.scl_c_oe),
        .sda_c_out(link.sda_c_out), .sda_c_oe(link.sda_c_oe), .sda_d_out(link.sda_d_out),
        .sda_d_oe(link.sda_d_oe), .scl(link.scl), .sda(link.sda));

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic fail(input string msg);
        err_total++;
        $display("MISMATCH at %0t: %s", $time, msg);
    endtask : fail

    task automatic chk_pos(input logic [4:0] got, input logic [4:0] exp);
        check_count++;
        if (got !== exp) fail($sformatf("wiper %h expected %h", got, exp));
    endtask : chk_pos

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
    endtask : chk_bit

    // {live, store} after a command taken by the target
    function automatic logic [9:0] model(input logic [7:0] c, input logic [7:0] d,
            input logic [9:0] s);
        case (c)
            wpc_pkg::CMD_LOAD_LIVE: return {d[7:3], s[4:0]};
            wpc_pkg::CMD_LOAD_STORED: return {s[9:5], d[7:3]};
            wpc_pkg::CMD_RECALL: return {s[4:0], s[4:0]};
            wpc_pkg::CMD_SAVE: return {s[9:5], s[9:5]};
            default: return s;
        endcase
    endfunction : model

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            if (n > 20) begin
                fail("bus hang");
                close_out();
            end
        end while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : ahb

    task automatic frame(input logic [6:0] a, input logic op, input logic [7:0] c,
            input logic [7:0] d);
        logic ok;
        int n;
        ok = (a == {6'h14, pin});
        ahb(1'b1, wpc_pkg::FRAME_OFS, {8'h00, d, c, op, a});
        ahb(1'b1, wpc_pkg::GO_OFS, 32'h0000_0001);
        n = 0;
        rd = 32'h0000_0001;
        while (rd[wpc_pkg::ST_BUSY] !== 1'b0 || rd[wpc_pkg::ST_WAIT] !== 1'b0) begin
            ahb(1'b0, wpc_pkg::STATUS_OFS, 32'h0000_0000);
            n++;
            if (n > 2000) begin
                fail("frame hang");
                close_out();
            end
        end
        if (ok && !op) exp_s = model(c, d, exp_s);
        chk_bit(rd[wpc_pkg::ST_NACK], !ok);
        chk_pos(wiper, exp_s[9:5]);
        chk_bit(store_busy, ok && !op && (c == wpc_pkg::CMD_LOAD_STORED
            || c == wpc_pkg::CMD_SAVE));
    endtask : frame

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        hresetn = 1'b0;
        factory_clear_n = 1'b0;
        pin = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        err_total = 0;
        check_count = 0;
        exp_s = 10'h000;
        cmds = '{wpc_pkg::CMD_LOAD_LIVE, wpc_pkg::CMD_LOAD_STORED, wpc_pkg::CMD_RECALL,
            wpc_pkg::CMD_SAVE, 8'h00, 8'h71};
        void'($urandom(88));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        factory_clear_n <= 1'b1;
        repeat (2) @(posedge hclk);
        chk_pos(wiper, 5'h00);
        ahb(1'b0, 8'h40, 32'h0000_0000);
        chk_bit(rd === 32'h0000_0000, 1'b1);
        $display("test reset done");
        frame(7'h28, 1'b0, wpc_pkg::CMD_LOAD_STORED, 8'hff);
        frame(7'h28, 1'b0, wpc_pkg::CMD_RECALL, 8'h00);
        frame(7'h28, 1'b0, wpc_pkg::CMD_LOAD_LIVE, 8'h5f);
        frame(7'h28, 1'b0, wpc_pkg::CMD_SAVE, 8'hf8);
        frame(7'h28, 1'b0, wpc_pkg::CMD_LOAD_LIVE, 8'h07);
        frame(7'h28, 1'b0, wpc_pkg::CMD_RECALL, 8'hff);
        frame(7'h28, 1'b0, 8'h91, 8'hf8);
        frame(7'h28, 1'b1, wpc_pkg::CMD_LOAD_LIVE, 8'hf8);
        $display("test commands done");
        frame(7'h30, 1'b0, wpc_pkg::CMD_LOAD_LIVE, 8'h40);
        frame(7'h2c, 1'b0, wpc_pkg::CMD_LOAD_LIVE, 8'h40);
        pin <= 1'b1;
        repeat (4) @(posedge hclk);
        frame(7'h29, 1'b0, wpc_pkg::CMD_LOAD_LIVE, 8'h30);
        frame(7'h28, 1'b0, wpc_pkg::CMD_LOAD_LIVE, 8'h60);
        pin <= 1'b0;
        repeat (4) @(posedge hclk);
        $display("test address done");
        for (int i = 0; i < 12; i++) begin
            frame(($urandom % 4 == 0) ? 7'($urandom) : 7'h28, 1'b0, cmds[$urandom % 6],
                8'($urandom));
        end
        $display("test random done");
        frame(7'h28, 1'b0, wpc_pkg::CMD_LOAD_STORED, 8'ha8);
        frame(7'h28, 1'b0, wpc_pkg::CMD_LOAD_LIVE, 8'h00);
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        exp_s[9:5] = exp_s[4:0];
        chk_pos(wiper, exp_s[9:5]);
        frame(7'h28, 1'b0, wpc_pkg::CMD_RECALL, 8'h00);
        $display("test power cycle done");
        close_out();
    end
endmodule : tb
